// ==== rtl/uart_rx_regs.svh ====
// Purpose: Register indices, field positions and reset values
// Assumes: Byte address is four times the register index
// Notes: Definitions only
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH
`define UFE_IDX_CTRL_REG 10'h098
`define UFE_IDX_BUF_REG 10'h099
`define UFE_IDX_PWR_REG 10'h087
`define UFE_IDX_ADDR_REG 10'h0A9
`define UFE_IDX_SMASK_REG 10'h0B9
`define UFE_BIT_SHARED 7
`define UFE_BIT_MODE1 6
`define UFE_BIT_FILTER 5
`define UFE_BIT_RXEN 4
`define UFE_BIT_TXNINTH 3
`define UFE_BIT_RXNINTH 2
`define UFE_BIT_TXDONE 1
`define UFE_BIT_RXDONE 0
`define UFE_BIT_VIEW 6
`define UFE_RST_ADDR 8'h00
`define UFE_SAMPLE_DIV 54
`define UFE_PHASE_S0 4'h7
`define UFE_PHASE_S1 4'h8
`define UFE_PHASE_VOTE 4'h9
`define UFE_DATA_BITS 4'h8
`endif

// ==== rtl/uart_rx_pkg.sv ====
// Purpose: Types shared by the receive extension
// Assumes: Nothing
// Notes: States carry no fixed codes
package uart_rx_pkg;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rxState_t;
endpackage

// ==== rtl/uart_frame_error_and_address_match.sv ====
// Purpose: Serial receiver with frame error flag and hardware address match
// Assumes: APB slave, one clock, rxd pin asynchronous
// Notes: Transmit path is not part of this block
//
// Added by the designer: the APB slave port.
`include "uart_rx_regs.svh"
module uart_frame_error_and_address_match #(
	parameter int SAMPLE_DIV = `UFE_SAMPLE_DIV,
	parameter int AW = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Serial line
	input wire logic rxd
);
	localparam int DW = $clog2(SAMPLE_DIV + 1);

	logic rxMeta_r, rxSync_r, rxPrev_r;
	logic [DW-1:0] divCnt_r, divCnt_nxt;
	logic [3:0] phase_r, phase_nxt, bitIdx_r, bitIdx_nxt;
	uart_rx_pkg::rxState_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic ninth_r, ninth_nxt;
	logic [1:0] smp_r, smp_nxt;
	logic [7:0] slvAddr_r, slvAddr_nxt, slvMask_r, slvMask_nxt, rxBuf_r, rxBuf_nxt;
	logic mode0_r, mode0_nxt, mode1_r, mode1_nxt, filtEn_r, filtEn_nxt, rxEn_r, rxEn_nxt;
	logic txNinth_r, txNinth_nxt, rxNinth_r, rxNinth_nxt, txDone_r, txDone_nxt;
	logic rxDone_r, rxDone_nxt, errFlag_r, errFlag_nxt, viewSel_r, viewSel_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic tick, vote, stopDone, match, qual, load, hit, wrEn, wrSc, errClr;
	logic [1:0] mode;
	logic [9:0] idx;
	logic [7:0] bcast, scRead;

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	always_comb begin
		mode = {mode1_r, mode0_r};
		idx = paddr[11:2];
		tick = (divCnt_r == '0);
		// Majority of the two held samples and the pin now
		vote = (smp_r[0] & smp_r[1]) | (smp_r[0] & rxSync_r) | (smp_r[1] & rxSync_r);
		stopDone = (state_r == uart_rx_pkg::RX_STOP) && tick && (phase_r == `UFE_PHASE_VOTE);
		bcast = slvAddr_r | slvMask_r;
		// Broadcast needs every one bit of address OR mask
		match = (((shift_r ^ slvAddr_r) & slvMask_r) == 8'h00) || ((shift_r & bcast) == bcast);
		// Address frames are told apart by a high ninth bit; mode 1 uses the stop bit
		qual = mode[1] ? ninth_r : vote;
		load = !rxDone_r && (!filtEn_r || (qual && match));
		// Upper bits tested by shift so that an AW of 12 leaves no empty slice
		hit = ((paddr >> 12) == '0) && (paddr[1:0] == 2'h0) &&
			(idx == `UFE_IDX_CTRL_REG || idx == `UFE_IDX_BUF_REG || idx == `UFE_IDX_PWR_REG ||
			idx == `UFE_IDX_ADDR_REG || idx == `UFE_IDX_SMASK_REG);
		wrEn = psel && penable && pready_r && pwrite && hit;
		wrSc = wrEn && (idx == `UFE_IDX_CTRL_REG);
		errClr = wrSc && viewSel_r && !pwdata[`UFE_BIT_SHARED];
		scRead = {viewSel_r ? errFlag_r : mode0_r, mode1_r, filtEn_r, rxEn_r,
			txNinth_r, rxNinth_r, txDone_r, rxDone_r};

		divCnt_nxt = (divCnt_r == DW'(SAMPLE_DIV - 1)) ? '0 : divCnt_r + 1'b1;
		phase_nxt = phase_r;
		bitIdx_nxt = bitIdx_r;
		state_nxt = state_r;
		shift_nxt = shift_r;
		ninth_nxt = ninth_r;
		smp_nxt = smp_r;
		slvAddr_nxt = slvAddr_r;
		slvMask_nxt = slvMask_r;
		rxBuf_nxt = rxBuf_r;
		mode0_nxt = mode0_r;
		mode1_nxt = mode1_r;
		filtEn_nxt = filtEn_r;
		rxEn_nxt = rxEn_r;
		txNinth_nxt = txNinth_r;
		rxNinth_nxt = rxNinth_r;
		txDone_nxt = txDone_r;
		rxDone_nxt = rxDone_r;
		errFlag_nxt = errFlag_r;
		viewSel_nxt = viewSel_r;

		// Software writes first so that hardware sets below win the same cycle
		if (wrSc) begin
			if (viewSel_r) begin
				if (!pwdata[`UFE_BIT_SHARED])
					errFlag_nxt = 1'b0;
			end else begin
				mode0_nxt = pwdata[`UFE_BIT_SHARED];
			end
			mode1_nxt = pwdata[`UFE_BIT_MODE1];
			filtEn_nxt = pwdata[`UFE_BIT_FILTER];
			rxEn_nxt = pwdata[`UFE_BIT_RXEN];
			txNinth_nxt = pwdata[`UFE_BIT_TXNINTH];
			rxNinth_nxt = pwdata[`UFE_BIT_RXNINTH];
			txDone_nxt = pwdata[`UFE_BIT_TXDONE];
			rxDone_nxt = pwdata[`UFE_BIT_RXDONE];
		end
		if (wrEn && idx == `UFE_IDX_PWR_REG)
			viewSel_nxt = pwdata[`UFE_BIT_VIEW];
		if (wrEn && idx == `UFE_IDX_ADDR_REG)
			slvAddr_nxt = pwdata[7:0];
		if (wrEn && idx == `UFE_IDX_SMASK_REG)
			slvMask_nxt = pwdata[7:0];

		case (state_r)
			uart_rx_pkg::RX_IDLE: begin
				// Mode 0 is synchronous and never enters the framed receiver
				if (rxEn_r && mode != 2'h0 && rxPrev_r && !rxSync_r) begin
					state_nxt = uart_rx_pkg::RX_START;
					phase_nxt = 4'h0;
					bitIdx_nxt = 4'h0;
					divCnt_nxt = '0;
				end
			end
			default: begin
				if (tick) begin
					phase_nxt = phase_r + 4'h1;
					if (phase_r == `UFE_PHASE_S0)
						smp_nxt[0] = rxSync_r;
					if (phase_r == `UFE_PHASE_S1)
						smp_nxt[1] = rxSync_r;
					if (phase_r == `UFE_PHASE_VOTE) begin
						case (state_r)
							uart_rx_pkg::RX_START: begin
								if (vote)
									state_nxt = uart_rx_pkg::RX_IDLE;
							end
							uart_rx_pkg::RX_DATA: begin
								shift_nxt = {vote, shift_r[7:1]};
								bitIdx_nxt = bitIdx_r + 4'h1;
							end
							uart_rx_pkg::RX_NINTH: begin
								ninth_nxt = vote;
							end
							default: begin
								// Stop decided at mid bit, then back to edge hunting
								state_nxt = uart_rx_pkg::RX_IDLE;
								if (!vote)
									errFlag_nxt = 1'b1;
								if (load) begin
									rxBuf_nxt = shift_r;
									rxNinth_nxt = mode[1] ? ninth_r : vote;
									rxDone_nxt = 1'b1;
								end
							end
						endcase
					end
					if (phase_r == 4'hF) begin
						case (state_r)
							uart_rx_pkg::RX_START: state_nxt = uart_rx_pkg::RX_DATA;
							uart_rx_pkg::RX_DATA: begin
								if (bitIdx_r == `UFE_DATA_BITS)
									state_nxt = mode[1] ? uart_rx_pkg::RX_NINTH : uart_rx_pkg::RX_STOP;
							end
							uart_rx_pkg::RX_NINTH: state_nxt = uart_rx_pkg::RX_STOP;
							default: state_nxt = state_r;
						endcase
					end
				end
			end
		endcase

		// One wait state: read data is captured as pready rises
		pready_nxt = psel && penable && !pready_r;
		pslverr_nxt = pready_nxt && !hit;
		prdata_nxt = 32'h0000_0000;
		if (pready_nxt && hit && !pwrite) begin
			if (idx == `UFE_IDX_CTRL_REG)
				prdata_nxt = {24'h00_0000, scRead};
			else if (idx == `UFE_IDX_BUF_REG)
				prdata_nxt = {24'h00_0000, rxBuf_r};
			else if (idx == `UFE_IDX_PWR_REG)
				prdata_nxt = {25'h000_0000, viewSel_r, 6'h00};
			else if (idx == `UFE_IDX_ADDR_REG)
				prdata_nxt = {24'h00_0000, slvAddr_r};
			else
				prdata_nxt = {24'h00_0000, slvMask_r};
		end
	end

	always_ff @(posedge clk) begin
		rxMeta_r <= rxd;
		rxSync_r <= rxMeta_r;
		if (!nrst) begin
			rxPrev_r <= 1'b1;
			divCnt_r <= '0;
			phase_r <= 4'h0;
			bitIdx_r <= 4'h0;
			state_r <= uart_rx_pkg::RX_IDLE;
			shift_r <= 8'h00;
			ninth_r <= 1'b0;
			smp_r <= 2'h3;
			slvAddr_r <= `UFE_RST_ADDR;
			slvMask_r <= `UFE_RST_ADDR;
			rxBuf_r <= 8'h00;
			{mode0_r, mode1_r, filtEn_r, rxEn_r} <= 4'h0;
			{txNinth_r, rxNinth_r, txDone_r, rxDone_r} <= 4'h0;
			errFlag_r <= 1'b0;
			viewSel_r <= 1'b0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			rxPrev_r <= rxSync_r;
			divCnt_r <= divCnt_nxt;
			phase_r <= phase_nxt;
			bitIdx_r <= bitIdx_nxt;
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			ninth_r <= ninth_nxt;
			smp_r <= smp_nxt;
			slvAddr_r <= slvAddr_nxt;
			slvMask_r <= slvMask_nxt;
			rxBuf_r <= rxBuf_nxt;
			{mode0_r, mode1_r, filtEn_r, rxEn_r} <= {mode0_nxt, mode1_nxt, filtEn_nxt, rxEn_nxt};
			{txNinth_r, rxNinth_r, txDone_r, rxDone_r} <= {txNinth_nxt, rxNinth_nxt, txDone_nxt, rxDone_nxt};
			errFlag_r <= errFlag_nxt;
			viewSel_r <= viewSel_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence badStart;
		state_r == uart_rx_pkg::RX_START && tick && phase_r == `UFE_PHASE_VOTE && vote;
	endsequence
	sequence readCtrl;
		psel && penable && !pready_r && !pwrite && idx == `UFE_IDX_CTRL_REG && hit;
	endsequence
	// A full receiver drops the frame and keeps its buffer
	sequence dropFrame;
		stopDone && rxDone_r && !wrSc;
	endsequence
	sequence bcastFrame;
		stopDone && filtEn_r && !rxDone_r && qual && ((shift_r & bcast) == bcast);
	endsequence

	errSet_a: assert property (stopDone && !vote |=> errFlag_r)
		else $error("stop bit zero did not set frame error");
	errSticky_a: assert property (errFlag_r && !errClr |=> errFlag_r)
		else $error("frame error cleared without software");
	viewRead_a: assert property (readCtrl |=>
		prdata_r[7] == ($past(viewSel_r) ? $past(errFlag_r) : $past(mode0_r)))
		else $error("shared bit read wrong storage");
	modeKeep_a: assert property (wrSc && viewSel_r |=> $stable(mode0_r))
		else $error("mode bit written while flag in view");
	filterDrop_a: assert property (stopDone && filtEn_r && !match |=> $stable(rxDone_r))
		else $error("unmatched address completed");
	noFilter_a: assert property (stopDone && !filtEn_r && !rxDone_r |=> rxDone_r && rxBuf_r == $past(shift_r))
		else $error("frame not loaded with filter off");
	openMask_a: assert property (slvMask_r == 8'h00 |-> match)
		else $error("zero mask did not match");
	ninthLoad_a: assert property (stopDone && load && mode[1] |=> rxNinth_r == $past(ninth_r))
		else $error("ninth bit not stored");
	startAbort_a: assert property (badStart |=> state_r == uart_rx_pkg::RX_IDLE)
		else $error("false start not aborted");
	modeZero_a: assert property (mode == 2'h0 && state_r == uart_rx_pkg::RX_IDLE |=>
		$stable(errFlag_r) || $past(errClr))
		else $error("frame error touched in mode 0");
	mode1Stop_a: assert property (stopDone && filtEn_r && !mode[1] && !vote && !wrSc |=> $stable(rxDone_r))
		else $error("mode 1 frame with bad stop completed");
	bcastLoad_a: assert property (bcastFrame |=> rxDone_r)
		else $error("broadcast address not accepted");
	dropFull_a: assert property (dropFrame |=> $stable(rxBuf_r))
		else $error("buffer overwritten while complete set");
	addrWrite_a: assert property (wrEn && idx == `UFE_IDX_ADDR_REG |=> slvAddr_r == 8'($past(pwdata)))
		else $error("slave address write lost");

	// Bus answers after one wait state, for one cycle only
	apbWait_a: assert property (psel && penable && !pready_r |=> pready_r)
		else $error("access not answered after one wait state");
	apbPulse_a: assert property (pready_r |=> !pready_r)
		else $error("ready held beyond one cycle");
endmodule

// ==== dv/serial_peer.sv ====
// Purpose: Remote node that sends frames onto the shared serial line
// Assumes: Line idles high; one bit lasts BIT_CLKS clocks
// Notes: The stop bit may be forced low to model a corrupted frame
module serial_peer #(
	parameter int BIT_CLKS = 32
) (
	// Clock
	input wire logic clk,
	// Serial line
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rxd = 1'b1;
	// Sends start, data LSB first, optional ninth bit, stop, then one idle bit
	task automatic send(input logic [7:0] d, input logic hasNinth, input logic ninth, input logic stopBit);
		logic [10:0] bits;
		int n;
		// Address frames carry the ninth bit high
		bits = hasNinth ? {stopBit, ninth, d, 1'b0} : {1'b1, stopBit, d, 1'b0};
		n = hasNinth ? 11 : 10;
		for (int i = 0; i <= n; i++) begin
			rxd <= (i < n) ? bits[i] : 1'b1;
			repeat (BIT_CLKS) @(posedge clk);
		end
	endtask
	// Short low pulse that a healthy receiver rejects as a false start
	task automatic pulse(input int lowClks);
		rxd <= 1'b0;
		repeat (lowClks) @(posedge clk);
		rxd <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk);
	endtask
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Register and frame tests for the receive extension
// Assumes: SAMPLE_DIV of 2, so one bit is 32 clocks
// Notes: Reads compare only the bits a step is about
`include "uart_rx_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] CTRL = {`UFE_IDX_CTRL_REG, 2'b00};
	localparam logic [11:0] BUF = {`UFE_IDX_BUF_REG, 2'b00};
	localparam logic [11:0] PWR = {`UFE_IDX_PWR_REG, 2'b00};
	localparam logic [11:0] ADDR = {`UFE_IDX_ADDR_REG, 2'b00};
	localparam logic [11:0] MASK = {`UFE_IDX_SMASK_REG, 2'b00};
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, rxd;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	int mismatches = 0;
	int testsRun = 0;
	uart_frame_error_and_address_match #(.SAMPLE_DIV(2), .AW(12)) uart_frame_error_and_address_match_inst (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd(rxd));
	serial_peer #(.BIT_CLKS(32)) serial_peer_inst (.clk(clk), .rxd(rxd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic completeRun();
		$display("comparisons %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Request holds until pready is sampled high; an idle edge follows
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
		output logic e);
		int n;
		logic late;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		late = (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (late) begin
			mismatches++;
			completeRun();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		check($sformatf("reg %h", a), r & m, x);
	endtask
	initial begin
		logic [31:0] r;
		logic e;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(ADDR, 32'hFF, 32'h00);
		rd(MASK, 32'hFF, 32'h00);
		apb(1'b0, 12'h000, 8'h00, r, e);
		check("slverr", {31'h0, e}, 32'h1);
		// Mode 1, filter on, all address bits don't care
		wr(CTRL, 8'hB0);
		serial_peer_inst.send(8'h5A, 1'b0, 1'b0, 1'b0);
		rd(CTRL, 32'h01, 32'h00);
		serial_peer_inst.send(8'h5A, 1'b0, 1'b0, 1'b1);
		rd(CTRL, 32'h01, 32'h01);
		rd(BUF, 32'hFF, 32'h5A);
		wr(PWR, 8'h40);
		rd(CTRL, 32'h80, 32'h80);
		wr(CTRL, 8'h10);
		rd(CTRL, 32'hF1, 32'h10);
		wr(PWR, 8'h00);
		rd(CTRL, 32'hF1, 32'h90);
		// Filter off; a bad frame while complete is set is dropped
		serial_peer_inst.send(8'hA5, 1'b0, 1'b0, 1'b1);
		rd(CTRL, 32'h01, 32'h01);
		serial_peer_inst.send(8'hC3, 1'b0, 1'b0, 1'b0);
		rd(BUF, 32'hFF, 32'hA5);
		wr(PWR, 8'h40);
		rd(CTRL, 32'h80, 32'h80);
		wr(CTRL, 8'h90);
		serial_peer_inst.send(8'h66, 1'b0, 1'b0, 1'b1);
		rd(CTRL, 32'h81, 32'h81);
		rd(BUF, 32'hFF, 32'h66);
		wr(CTRL, 8'h10);
		wr(PWR, 8'h00);
		// Mode 3 with hardware address match
		wr(ADDR, 8'hA4);
		wr(MASK, 8'hFA);
		rd(ADDR, 32'hFF, 32'hA4);
		rd(MASK, 32'hFF, 32'hFA);
		wr(CTRL, 8'hF0);
		serial_peer_inst.send(8'hA0, 1'b1, 1'b1, 1'b1);
		rd(CTRL, 32'h05, 32'h05);
		rd(BUF, 32'hFF, 32'hA0);
		wr(CTRL, 8'hF0);
		serial_peer_inst.send(8'hA2, 1'b1, 1'b1, 1'b1);
		rd(CTRL, 32'h01, 32'h00);
		serial_peer_inst.send(8'hFF, 1'b1, 1'b1, 1'b1);
		rd(CTRL, 32'h01, 32'h01);
		wr(CTRL, 8'hF0);
		serial_peer_inst.send(8'hA0, 1'b1, 1'b0, 1'b1);
		rd(CTRL, 32'h01, 32'h00);
		wr(CTRL, 8'hD0);
		serial_peer_inst.send(8'h3C, 1'b1, 1'b0, 1'b1);
		rd(CTRL, 32'h05, 32'h01);
		rd(BUF, 32'hFF, 32'h3C);
		// Mode 2, after a false start that must be rejected
		wr(CTRL, 8'h70);
		serial_peer_inst.pulse(4);
		rd(CTRL, 32'h01, 32'h00);
		serial_peer_inst.send(8'hA1, 1'b1, 1'b1, 1'b1);
		rd(CTRL, 32'hC5, 32'h45);
		rd(BUF, 32'hFF, 32'hA1);
		// Mode 0 never frames, so a low stop leaves both flags clear
		wr(CTRL, 8'h10);
		serial_peer_inst.send(8'h00, 1'b0, 1'b0, 1'b0);
		wr(PWR, 8'h40);
		rd(CTRL, 32'h81, 32'h00);
		completeRun();
	end
endmodule
